// *** rtl/pga_cfg.svh ***
/*
  Constants of the gain and readback block: word layout, register
  addresses, field positions, reset values and limits.
  Assumes it is included by bare name from the package and the design.
*/
`ifndef PGA_CFG_SVH
`define PGA_CFG_SVH

// Serial word layout.
`define PGA_WORD_W 32
`define PGA_ADDR_LSB 0
`define PGA_ADDR_MSB 2
`define PGA_BANK_LSB 3
`define PGA_BANK_MSB 4

// Register addresses within the bank.
`define PGA_BANK_SETUP 2'h1
`define PGA_ADDR_READBACK 3'h0
`define PGA_ADDR_GAIN 3'h1
`define PGA_ADDR_TRIM 3'h5

// Register 1 fields.
`define PGA_GAIN_LSB 12
`define PGA_GAIN_MSB 16
`define PGA_MULT_BIT 28
`define PGA_GAIN_RST 5'h00
`define PGA_MULT_RST 1'h0
`define PGA_GAIN_MAX 5'h18

// Register 5: only bits 16 to 0 are implemented.
`define PGA_TRIM_MASK 32'h0001_FFFF
`define PGA_TRIM_RST 32'h0000_AAAD

// Readback word fields.
`define PGA_RB_ADDR 3'h0
`define PGA_RB_BANK 2'h1
`define PGA_RB_VER_LSB 5
`define PGA_RB_VER_MSB 6
`define PGA_RB_Q_LSB 16
`define PGA_RB_Q_MSB 23
`define PGA_RB_I_LSB 24
`define PGA_RB_I_MSB 31

// Offset DACs start at half scale.
`define PGA_DAC_RST 8'h80

`endif

// *** rtl/pga_pkg.sv ***
/*
  Types of the gain and readback block.
  Assumes the constants header is on the include path.
*/
package pga_pkg;
  `include "pga_cfg.svh"

  typedef enum logic [0:0] {
    PGA_IDLE,
    PGA_SEND
  } pga_rb_state_t;

  typedef logic [`PGA_WORD_W-1:0] pga_word_t;
endpackage

// *** rtl/pga_gain_readback.sv ***
/*
  Gain word and readback logic of a receiver baseband gain amplifier.
  Holds register 1 gain fields, register 5 trims and both offset DAC values,
  forms the effective gain word from the three fast reduce pins and
  shifts the readback word out on request.
  Assumes a host on the three-wire serial port (clock, data, latch enable)
  that shifts bit 0 first, and calibration logic on ref_clk that loads
  the offset DAC values.
*/
`timescale 1ns/1ps
`default_nettype none

`include "pga_cfg.svh"

module pga_gain_readback
  import pga_pkg::*;
#(
  // Version code; the default value is arbitrary.
  parameter logic [1:0] VERSION = 2'h2
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Three-wire serial port.
  input wire logic ser_clk,
  input wire logic ser_data_in,
  input wire logic ser_latch,
  output logic ser_data_out,
  output logic ser_data_oe,
  // Fast reduce pins.
  input wire logic fast_reduce_pin_0,
  input wire logic fast_reduce_pin_1,
  input wire logic fast_reduce_pin_2,
  // Offset DAC load from calibration logic.
  input wire logic offset_load,
  input wire logic [7:0] quad_offset_load_value,
  input wire logic [7:0] inphase_offset_load_value,
  // Outputs to the analog side.
  output logic [4:0] effective_gain_word,
  output logic gain_step_double,
  output logic [`PGA_WORD_W-1:0] bias_trim_setup,
  output logic [7:0] quad_offset_dac_value,
  output logic [7:0] inphase_offset_dac_value
);
  import pga_pkg::*;

  // Synchroniser order: ser_clk, ser_data_in, ser_latch, then pins 0 to 2.
  localparam int SYNC_W = 6;

  // Pin synchronisers.
  logic [SYNC_W-1:0] pin_raw;
  wire logic [SYNC_W-1:0] sync_b;

  // Edge detector state.
  logic ser_clk_prev;
  logic ser_latch_prev;
  logic next_ser_clk_prev;
  logic next_ser_latch_prev;

  // Serial input state.
  pga_word_t shift_in;
  pga_word_t next_shift_in;

  // Gain state.
  logic [4:0] gain_prog;
  logic [4:0] next_gain_prog;
  logic next_gain_step_double;
  logic [4:0] next_effective_gain_word;

  // Setup and offset DAC state.
  pga_word_t next_bias_trim_setup;
  logic [7:0] next_quad;
  logic [7:0] next_inphase;

  // Readback state.
  pga_rb_state_t rb_state;
  pga_rb_state_t next_rb_state;
  pga_word_t shift_out;
  pga_word_t next_shift_out;
  logic [5:0] out_count;
  logic [5:0] next_out_count;
  logic next_ser_data_out;
  logic next_ser_data_oe;

  // Decoded strobes and fields.
  logic clk_rise;
  logic latch_rise;
  logic write_commit;
  logic [2:0] wr_addr;
  logic [1:0] wr_bank;
  logic [2:0] fast_count;
  logic [4:0] reduction;
  logic [4:0] gain_used;
  pga_word_t rb_word;

  assign pin_raw = {fast_reduce_pin_2, fast_reduce_pin_1, fast_reduce_pin_0,
                    ser_latch, ser_data_in, ser_clk};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_sync
      logic stage_a;
      logic stage_b;
      // Only the second stage is read, so a metastable first stage never reaches logic.
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          stage_a <= 1'b0;
          stage_b <= 1'b0;
        end else begin
          stage_a <= pin_raw[gi];
          stage_b <= stage_a;
        end
      end
      assign sync_b[gi] = stage_b;
    end
  endgenerate

  // Edge detectors start low, matching the idle level of both pins.
  always_comb begin
    next_ser_clk_prev = sync_b[0];
    next_ser_latch_prev = sync_b[2];
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ser_clk_prev <= 1'b0;
      ser_latch_prev <= 1'b0;
    end else begin
      ser_clk_prev <= next_ser_clk_prev;
      ser_latch_prev <= next_ser_latch_prev;
    end
  end

  always_comb begin
    clk_rise = sync_b[0] && !ser_clk_prev;
    latch_rise = sync_b[2] && !ser_latch_prev;
    wr_addr = shift_in[`PGA_ADDR_MSB:`PGA_ADDR_LSB];
    wr_bank = shift_in[`PGA_BANK_MSB:`PGA_BANK_LSB];
    // Words latched while a readback runs are dropped, not queued.
    write_commit = latch_rise && (rb_state == PGA_IDLE) && (wr_bank == `PGA_BANK_SETUP);
    rb_word = '0;
    rb_word[`PGA_ADDR_MSB:`PGA_ADDR_LSB] = `PGA_RB_ADDR;
    rb_word[`PGA_BANK_MSB:`PGA_BANK_LSB] = `PGA_RB_BANK;
    rb_word[`PGA_RB_VER_MSB:`PGA_RB_VER_LSB] = VERSION;
    rb_word[`PGA_RB_Q_MSB:`PGA_RB_Q_LSB] = quad_offset_dac_value;
    rb_word[`PGA_RB_I_MSB:`PGA_RB_I_LSB] = inphase_offset_dac_value;
  end

  always_comb begin
    next_shift_in = shift_in;
    // Bit 0 arrives first, so each new bit enters at the top.
    if (clk_rise && !sync_b[2] && rb_state == PGA_IDLE) begin
      next_shift_in = {sync_b[1], shift_in[`PGA_WORD_W-1:1]};
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shift_in <= '0;
    end else begin
      shift_in <= next_shift_in;
    end
  end

  always_comb begin
    // Pin 2 is the most significant bit of the count.
    fast_count = {sync_b[5], sync_b[4], sync_b[3]};
    // Double steps shift the count left by one.
    reduction = gain_step_double ? {1'b0, fast_count, 1'b0} : {2'b00, fast_count};
    // Settings above the usable top are held at the top.
    gain_used = (gain_prog > `PGA_GAIN_MAX) ? `PGA_GAIN_MAX : gain_prog;
    // Recomputed every cycle, so pin changes need no serial write.
    if (gain_used > reduction) begin
      next_effective_gain_word = gain_used - reduction;
    end else begin
      next_effective_gain_word = 5'h00;
    end
    next_gain_prog = gain_prog;
    next_gain_step_double = gain_step_double;
    if (write_commit && wr_addr == `PGA_ADDR_GAIN) begin
      next_gain_prog = shift_in[`PGA_GAIN_MSB:`PGA_GAIN_LSB];
      next_gain_step_double = shift_in[`PGA_MULT_BIT];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gain_prog <= `PGA_GAIN_RST;
      gain_step_double <= `PGA_MULT_RST;
      effective_gain_word <= 5'h00;
    end else begin
      gain_prog <= next_gain_prog;
      gain_step_double <= next_gain_step_double;
      effective_gain_word <= next_effective_gain_word;
    end
  end

  always_comb begin
    next_bias_trim_setup = bias_trim_setup;
    next_quad = quad_offset_dac_value;
    next_inphase = inphase_offset_dac_value;
    if (write_commit && wr_addr == `PGA_ADDR_TRIM) begin
      next_bias_trim_setup = shift_in & `PGA_TRIM_MASK;
    end
    // A load during a readback shows only in the next one, as the word is frozen.
    if (offset_load) begin
      next_quad = quad_offset_load_value;
      next_inphase = inphase_offset_load_value;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bias_trim_setup <= `PGA_TRIM_RST;
      quad_offset_dac_value <= `PGA_DAC_RST;
      inphase_offset_dac_value <= `PGA_DAC_RST;
    end else begin
      bias_trim_setup <= next_bias_trim_setup;
      quad_offset_dac_value <= next_quad;
      inphase_offset_dac_value <= next_inphase;
    end
  end

  always_comb begin
    next_rb_state = rb_state;
    next_shift_out = shift_out;
    next_out_count = out_count;
    next_ser_data_out = ser_data_out;
    next_ser_data_oe = ser_data_oe;
    case (rb_state)
      PGA_IDLE: begin
        if (write_commit && wr_addr == `PGA_ADDR_READBACK) begin
          // Readback request: the word is frozen and bit 0 driven at once.
          next_shift_out = {1'b0, rb_word[`PGA_WORD_W-1:1]};
          next_ser_data_out = rb_word[0];
          next_ser_data_oe = 1'b1;
          next_out_count = 6'h00;
          next_rb_state = PGA_SEND;
        end
      end
      PGA_SEND: begin
        // A new latch pulse aborts a readback still in progress.
        if (latch_rise || (clk_rise && out_count == 6'h1F)) begin
          next_ser_data_oe = 1'b0;
          next_ser_data_out = 1'b0;
          next_rb_state = PGA_IDLE;
        end else if (clk_rise) begin
          next_ser_data_out = shift_out[0];
          next_shift_out = {1'b0, shift_out[`PGA_WORD_W-1:1]};
          next_out_count = out_count + 6'h01;
        end
      end
      default: begin
        next_rb_state = PGA_IDLE;
        next_ser_data_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rb_state <= PGA_IDLE;
      shift_out <= '0;
      out_count <= 6'h00;
      ser_data_out <= 1'b0;
      ser_data_oe <= 1'b0;
    end else begin
      rb_state <= next_rb_state;
      shift_out <= next_shift_out;
      out_count <= next_out_count;
      ser_data_out <= next_ser_data_out;
      ser_data_oe <= next_ser_data_oe;
    end
  end
endmodule

`default_nettype wire

// *** test/pga_gain_readback_props.sv ***
/*
  Port checker for the gain and readback block, bound at the file foot.
  Assumes the host holds each serial clock level at least four ref_clk cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module pga_gain_readback_props (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Serial port.
  input wire logic ser_clk,
  input wire logic ser_latch,
  input wire logic ser_data_out,
  input wire logic ser_data_oe,
  // Pins and load.
  input wire logic fast_reduce_pin_0,
  input wire logic fast_reduce_pin_1,
  input wire logic fast_reduce_pin_2,
  input wire logic offset_load,
  // Outputs.
  input wire logic [4:0] effective_gain_word,
  input wire logic gain_step_double,
  input wire logic [31:0] bias_trim_setup,
  input wire logic [7:0] quad_offset_dac_value,
  input wire logic [7:0] inphase_offset_dac_value
);
  logic [4:0] prv, next_prv;
  logic [3:0] quiet, next_quiet, ckq, next_ckq;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Counters of quiet spans stand in for long repetitions.
  always_comb begin
    next_prv = {fast_reduce_pin_2, fast_reduce_pin_1, fast_reduce_pin_0, ser_latch, ser_clk};
    next_quiet = (next_prv[4:1] != prv[4:1]) ? 4'h0 : quiet + 4'(quiet != 4'hf);
    next_ckq = (ser_clk && !prv[0]) ? 4'h0 : ckq + 4'(ckq != 4'hf);
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prv <= 5'h00;
      quiet <= 4'h0;
      ckq <= 4'h0;
    end else begin
      prv <= next_prv;
      quiet <= next_quiet;
      ckq <= next_ckq;
    end
  end
  gain_range_a: assert property (effective_gain_word <= 5'h18)
    else $error("gain above 24");
  reduce_span_a: assert property (quiet >= 4'h8 && next_prv[4:2] == 3'h7 |->
    effective_gain_word <= (gain_step_double ? 5'h0a : 5'h11)) else $error("reduction short");
  outputs_hold_a: assert property (quiet >= 4'ha |-> $stable(effective_gain_word) &&
    $stable(gain_step_double) && $stable(bias_trim_setup)) else $error("output moved");
  trim_upper_zero_a: assert property (bias_trim_setup[31:17] == 15'h0)
    else $error("trim upper bits set");
  dac_hold_a: assert property (!offset_load && !$past(offset_load) |->
    $stable(quad_offset_dac_value) && $stable(inphase_offset_dac_value)) else $error("dac moved");
  oe_start_a: assert property ($rose(ser_data_oe) |->
    $past(ser_latch, 3) || $past(ser_latch, 4) || $past(ser_latch, 5)) else $error("oe cause");
  oe_end_a: assert property ($fell(ser_data_oe) |-> $past(ser_clk, 3) ||
    $past(ser_clk, 4) || $past(ser_latch, 3) || $past(ser_latch, 4)) else $error("oe drop");
  bit_hold_a: assert property (ser_data_oe && $past(ser_data_oe) && ckq >= 4'h5 |->
    $stable(ser_data_out)) else $error("bit moved");
endmodule
bind pga_gain_readback pga_gain_readback_props u_props (.ref_clk(ref_clk), .rst(rst),
  .ser_clk(ser_clk), .ser_latch(ser_latch), .ser_data_out(ser_data_out),
  .ser_data_oe(ser_data_oe), .fast_reduce_pin_0(fast_reduce_pin_0),
  .fast_reduce_pin_1(fast_reduce_pin_1), .fast_reduce_pin_2(fast_reduce_pin_2),
  .offset_load(offset_load), .effective_gain_word(effective_gain_word),
  .gain_step_double(gain_step_double), .bias_trim_setup(bias_trim_setup),
  .quad_offset_dac_value(quad_offset_dac_value),
  .inphase_offset_dac_value(inphase_offset_dac_value));
`default_nettype wire

// *** test/pga_host_model.sv ***
/*
  Host on the three-wire serial port.
  Assumes ref_clk paces it; ser_clk is 400 ns in writes and 450 ns in readback, and still between frames.
*/
`timescale 1ns/1ps
`default_nettype none
module pga_host_model (
  // Clock and readback line.
  input wire logic ref_clk,
  input wire logic ser_data_out,
  // Serial port.
  output logic ser_clk,
  output logic ser_data_in,
  output logic ser_latch
);
  initial begin
    ser_clk = 1'b0;
    ser_data_in = 1'b0;
    ser_latch = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic send(input logic [31:0] w);
    tick(1);
    for (int i = 0; i < 32; i++) begin
      ser_data_in <= w[i];
      tick(4);
      ser_clk <= 1'b1;
      tick(4);
      ser_clk <= 1'b0;
    end
    ser_latch <= 1'b1;
    tick(4);
    ser_latch <= 1'b0;
    tick(8);
  endtask
  task automatic fetch(output logic [31:0] w);
    send(32'h0000_0008);
    for (int i = 0; i < 32; i++) begin
      @(negedge ref_clk);
      w[i] = ser_data_out;
      @(posedge ref_clk);
      ser_clk <= 1'b1;
      // The unused data line toggles so a stale level is never mistaken.
      ser_data_in <= ~ser_data_in;
      tick(4);
      ser_clk <= 1'b0;
      tick(4);
    end
  endtask
endmodule
`default_nettype wire

// *** test/pga_gain_readback_tb.sv ***
/*
  Self-checking bench for the gain and readback block.
  Assumes the host model and the bound checker beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module pga_gain_readback_tb;
  import pga_pkg::*;
  // Version code; the value is arbitrary.
  localparam logic [1:0] VER = 2'h3;
  logic ref_clk, rst, sck, sdi, sle, sdo, soe, ld, dbl, d;
  logic [2:0] pins;
  logic [7:0] q_ld, i_ld, q_dac, i_dac;
  logic [4:0] gain, g;
  pga_word_t trim, rb, w;
  int fail_count, n_compared;
  pga_gain_readback #(.VERSION(VER)) dut (.ref_clk(ref_clk), .rst(rst), .ser_clk(sck),
    .ser_data_in(sdi), .ser_latch(sle), .ser_data_out(sdo), .ser_data_oe(soe),
    .fast_reduce_pin_0(pins[0]), .fast_reduce_pin_1(pins[1]), .fast_reduce_pin_2(pins[2]),
    .offset_load(ld), .quad_offset_load_value(q_ld), .inphase_offset_load_value(i_ld),
    .effective_gain_word(gain), .gain_step_double(dbl), .bias_trim_setup(trim),
    .quad_offset_dac_value(q_dac), .inphase_offset_dac_value(i_dac));
  pga_host_model host (.ref_clk(ref_clk), .ser_data_out(sdo), .ser_clk(sck),
    .ser_data_in(sdi), .ser_latch(sle));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  function automatic logic [4:0] eff(input logic [4:0] g, input logic [2:0] p, input logic d);
    int r;
    r = int'(g > 5'h18 ? 5'h18 : g) - (d ? 2 * p : p);
    return r < 0 ? 5'h00 : 5'(r);
  endfunction
  task automatic rb_check;
    host.fetch(rb);
    chk("readback", {i_ld, q_ld, 9'h000, VER, 2'h1, 3'h0}, rb);
    chk("dacs", {16'h0000, i_ld, q_ld}, {16'h0000, i_dac, q_dac});
    chk("oe", 32'h0, 32'(soe));
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    ld = 1'b0;
    pins = 3'h0;
    q_ld = 8'h80;
    i_ld = 8'h80;
    void'($urandom(32'h0000_66f5));
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    host.tick(4);
    @(negedge ref_clk);
    chk("reset gain", 32'h0, {27'h0, gain});
    chk("reset trim", 32'h0000_aaad, trim);
    rb_check();
    for (int k = 0; k < 14; k++) begin
      g = k < 2 ? 5'h18 + 5'(7 * k) : 5'($urandom);
      d = 1'($urandom);
      host.send({3'h0, d, 11'($urandom), g, 7'h00, 5'h09});
      for (int p = 0; p < 8; p++) begin
        @(posedge ref_clk);
        pins <= 3'(p);
        host.tick(6);
        @(negedge ref_clk);
        chk("gain", {27'h0, eff(g, 3'(p), d)}, {27'h0, gain});
      end
      chk("step", {31'h0, d}, {31'h0, dbl});
    end
    w = $urandom;
    w[4:0] = 5'h0d;
    host.send(w);
    chk("trim", w & 32'h0001_ffff, trim);
    for (int k = 0; k < 2; k++) begin
      host.send({15'($urandom), 5'h1f, 7'h00, k ? 5'h11 : 5'h0b});
      chk("ignored gain", {27'h0, eff(g, 3'h7, d)}, {27'h0, gain});
      chk("ignored trim", w & 32'h0001_ffff, trim);
    end
    @(posedge ref_clk);
    q_ld <= 8'($urandom);
    i_ld <= 8'($urandom);
    ld <= 1'b1;
    @(posedge ref_clk);
    ld <= 1'b0;
    rb_check();
    tally_and_finish();
  end
  initial begin
    repeat (30000) @(posedge ref_clk);
    fail_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
